/* design/completer_request_descriptor_pkg.sv */
package completer_request_descriptor_pkg;

    // Descriptor geometry
    localparam int DESC_W         = 128;
    localparam int HALF_W         = 64;

    // Field positions (least significant bit of each field)
    localparam int AT_LSB         = 0;
    localparam int ADDR_LSB       = 2;
    localparam int DWCNT_LSB      = 64;
    localparam int TYPE_LSB       = 75;
    localparam int REQID_LSB      = 80;
    localparam int TAG_LSB        = 96;
    localparam int TFUNC_LSB      = 104;
    localparam int MSGCODE_LSB    = 104;
    localparam int BARID_LSB      = 112;
    localparam int ROUTE_LSB      = 112;
    localparam int APER_LSB       = 115;
    localparam int TC_LSB         = 121;
    localparam int NS_BIT         = 124;
    localparam int RO_BIT         = 125;
    localparam int IDO_BIT        = 126;
    localparam int SNOOP_LSB      = 0;
    localparam int NOSNOOP_LSB    = 16;
    localparam int OBFF_LSB       = 32;
    localparam int DESTID_LSB     = 0;
    localparam int VDM_LSB        = 32;
    localparam int ATS_LSB        = 0;

    // Request type codes
    localparam logic [3:0] TYPE_MEM_RD  = 4'h0;
    localparam logic [3:0] TYPE_MEM_WR  = 4'h1;
    localparam logic [3:0] TYPE_IO_RD   = 4'h2;
    localparam logic [3:0] TYPE_IO_WR   = 4'h3;
    localparam logic [3:0] TYPE_FADD    = 4'h4;
    localparam logic [3:0] TYPE_SWAP    = 4'h5;
    localparam logic [3:0] TYPE_CAS     = 4'h6;
    localparam logic [3:0] TYPE_LOCK_RD = 4'h7;
    localparam logic [3:0] TYPE_MSG     = 4'hC;
    localparam logic [3:0] TYPE_MSG_VDM = 4'hD;
    localparam logic [3:0] TYPE_MSG_ATS = 4'hE;

    // Fixed field values
    localparam logic [2:0]   BAR_ROM_ID  = 3'h6;
    localparam logic [2:0]   ROUTE_BY_ID = 3'h2;
    localparam logic [127:0] RST_DESC    = 128'h0;

    typedef enum logic [3:0] {
        REQ_MEM_RD,
        REQ_MEM_WR,
        REQ_IO_RD,
        REQ_IO_WR,
        REQ_FADD,
        REQ_SWAP,
        REQ_CAS,
        REQ_LOCK_RD,
        REQ_CFG0_RD,
        REQ_CFG1_RD,
        REQ_CFG0_WR,
        REQ_CFG1_WR,
        REQ_MSG,
        REQ_MSG_VDM,
        REQ_MSG_ATS
    } req_kind_t;

    typedef enum logic [1:0] {
        MSG_GENERAL,
        MSG_LTR,
        MSG_OBFF
    } msg_kind_t;

    typedef struct packed {
        req_kind_t   kind;
        msg_kind_t   msg_kind;
        logic [1:0]  at;
        logic [61:0] addr;
        logic [10:0] dw_cnt;
        logic [15:0] req_id;
        logic [7:0]  tag;
        logic [7:0]  tgt_func;
        logic [2:0]  bar_num;
        logic        bar_is_64;
        logic        rom_hit;
        logic        is_vf;
        logic [5:0]  bar_aper;
        logic [5:0]  vf_aper;
        logic [2:0]  tc;
        logic        ns;
        logic        ro;
        logic        ido;
        logic [7:0]  msg_code;
        logic [2:0]  msg_route;
        logic [15:0] ltr_snoop;
        logic [15:0] ltr_nosnoop;
        logic [3:0]  obff;
        logic [15:0] dest_id;
        logic [31:0] hdr_dw2;
        logic [31:0] hdr_dw3;
    } req_info_t;

endpackage : completer_request_descriptor_pkg

/* design/completer_request_descriptor.sv */
// Behaviour
// - Memory, I/O, atomic requests carry matched BAR number in 114:112, ROM is 110.
// - A 64-bit BAR pair reports its lower BAR, so only 0, 2, 4 or 6.
// - Memory, I/O, atomic requests carry log2 BAR aperture in 120:115.
// - Virtual-function hits report the aperture of one function's space.
// - Transaction class goes into bits 123:121.
// - No-snoop flag at bit 124, relaxed ordering at bit 125.
// - ID-based ordering at bit 126, only for memory, atomic requests and messages, never I/O.
// - LTR messages copy snoop latency into bits 15:0.
// - LTR messages copy no-snoop latency into bits 31:16.
// - OBFF messages carry their four-bit code in bits 35:32.
// - Every message carries its message code in bits 111:104.
// - Every message carries its routing subfield in bits 114:112.
// - ID-routed vendor messages carry destination ID in bits 15:0.
// - Vendor messages copy header doubleword 3 into bits 63:32.
// - ATS messages copy header doublewords 2 and 3 into bits 63:0.
// - Type codes 0000 to 0110 for memory, I/O and atomic requests.
// - Type 0111 for locked reads, only on legacy devices.
// - Configuration types 1000 to 1011 never appear on this stream.
// - Messages use 1100, 1101, 1110; code 1111 is never produced.
// - Sixteen-byte descriptor: two beats on 64-bit stream, one beat otherwise.
// - Request type code sits in bits 78:75.
`timescale 1ns/10ps
`default_nettype none

module completer_request_descriptor
    import completer_request_descriptor_pkg::*;
#(
    parameter int   STREAM_W   = 128,
    parameter logic LEGACY_DEV = 1'b0
)
(
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire logic                in_valid_i,
    input  wire req_info_t           in_req_i,
    output logic                     in_ready_o,
    output logic                     out_valid_o,
    output logic [((STREAM_W == 64) ? HALF_W : DESC_W)-1:0] out_data_o,
    output logic                     out_last_o,
    input  wire logic                out_ready_i,
    output logic                     drop_o
);

    localparam int OUT_W = (STREAM_W == 64) ? HALF_W : DESC_W;
    localparam int BEATS = (STREAM_W == 64) ? 2 : 1;

    generate
        if (STREAM_W != 64 && STREAM_W != 128 && STREAM_W != 256)
        begin : g_bad_width
            $error("STREAM_W must be 64, 128 or 256");
        end
    endgenerate

    // Type code of a request kind
    function automatic logic [3:0] type_code(input req_kind_t k);
        logic [3:0] c;
        c = TYPE_MEM_RD;
        case (k)
            REQ_MEM_RD:  c = TYPE_MEM_RD;
            REQ_MEM_WR:  c = TYPE_MEM_WR;
            REQ_IO_RD:   c = TYPE_IO_RD;
            REQ_IO_WR:   c = TYPE_IO_WR;
            REQ_FADD:    c = TYPE_FADD;
            REQ_SWAP:    c = TYPE_SWAP;
            REQ_CAS:     c = TYPE_CAS;
            REQ_LOCK_RD: c = TYPE_LOCK_RD;
            REQ_MSG:     c = TYPE_MSG;
            REQ_MSG_VDM: c = TYPE_MSG_VDM;
            REQ_MSG_ATS: c = TYPE_MSG_ATS;
            default:     c = TYPE_MEM_RD;
        endcase
        return c;
    endfunction : type_code

    // Whether a request may enter the stream
    function automatic logic passes(input req_kind_t k);
        logic ok;
        ok = 1'b1;
        case (k)
            REQ_CFG0_RD, REQ_CFG1_RD, REQ_CFG0_WR, REQ_CFG1_WR:
                ok = 1'b0;
            REQ_LOCK_RD:
                ok = LEGACY_DEV;
            default:
                ok = 1'b1;
        endcase
        return ok;
    endfunction : passes

    function automatic logic is_message(input req_kind_t k);
        return (k == REQ_MSG) || (k == REQ_MSG_VDM) || (k == REQ_MSG_ATS);
    endfunction : is_message

    function automatic logic is_memory(input req_kind_t k);
        logic m;
        m = 1'b0;
        case (k)
            REQ_MEM_RD, REQ_MEM_WR, REQ_LOCK_RD, REQ_FADD, REQ_SWAP, REQ_CAS:
                m = 1'b1;
            default:
                m = 1'b0;
        endcase
        return m;
    endfunction : is_memory

    // Descriptor assembly from a decoded request
    function automatic logic [DESC_W-1:0] build_desc(input req_info_t r);
        logic [DESC_W-1:0] d;
        logic [2:0]        bar;
        logic              msg;
        logic              mem;
        d   = RST_DESC;
        msg = is_message(r.kind);
        mem = is_memory(r.kind);
        bar = r.bar_num;
        // Common header fields
        d[DWCNT_LSB +: 11] = r.dw_cnt;
        d[TYPE_LSB +: 4]   = type_code(r.kind);
        d[REQID_LSB +: 16] = r.req_id;
        d[TAG_LSB +: 8]    = r.tag;
        d[TC_LSB +: 3]     = r.tc;
        d[NS_BIT]          = r.ns;
        d[RO_BIT]          = r.ro;
        d[IDO_BIT]         = r.ido & (mem | msg);
        if (!msg)
        begin
            // Memory, I/O and atomic layout
            if (mem)
            begin
                d[AT_LSB +: 2] = r.at;
            end
            d[ADDR_LSB +: 62] = r.addr;
            d[TFUNC_LSB +: 8] = r.tgt_func;
            if (r.rom_hit)
            begin
                bar = BAR_ROM_ID;
            end
            else if (r.bar_is_64)
            begin
                bar = {r.bar_num[2:1], 1'b0};
            end
            d[BARID_LSB +: 3] = bar;
            d[APER_LSB +: 6]  = r.is_vf ? r.vf_aper : r.bar_aper;
        end
        else
        begin
            d[MSGCODE_LSB +: 8] = r.msg_code;
            d[ROUTE_LSB +: 3]   = r.msg_route;
            case (r.kind)
                REQ_MSG_VDM:
                begin
                    if (r.msg_route == ROUTE_BY_ID)
                    begin
                        d[DESTID_LSB +: 16] = r.dest_id;
                    end
                    d[VDM_LSB +: 32] = r.hdr_dw3;
                end
                REQ_MSG_ATS:
                begin
                    d[ATS_LSB +: 64] = {r.hdr_dw3, r.hdr_dw2};
                end
                default:
                begin
                    case (r.msg_kind)
                        MSG_LTR:
                        begin
                            d[SNOOP_LSB +: 16]   = r.ltr_snoop;
                            d[NOSNOOP_LSB +: 16] = r.ltr_nosnoop;
                        end
                        MSG_OBFF:
                        begin
                            d[OBFF_LSB +: 4] = r.obff;
                        end
                        default:
                        begin
                            d[OBFF_LSB +: 4] = 4'h0;
                        end
                    endcase
                end
            endcase
        end
        return d;
    endfunction : build_desc

    // Two-entry buffer: slot0 is the head
    logic [DESC_W-1:0] slot0_q;
    logic [DESC_W-1:0] slot0_d;
    logic [DESC_W-1:0] slot1_q;
    logic [DESC_W-1:0] slot1_d;
    logic [1:0]        count_q;
    logic [1:0]        count_d;
    logic              beat_q;
    logic              beat_d;
    logic              ready_q;
    logic              valid_q;
    logic [OUT_W-1:0]  data_q;
    logic              last_q;
    logic              drop_q;
    logic [DESC_W-1:0] new_desc;
    logic [DESC_W-1:0] sel_beat;
    logic              push;
    logic              store;
    logic              take;
    logic              last_beat;
    logic              pop;

    assign new_desc  = build_desc(in_req_i);
    assign push      = in_valid_i & ready_q;
    assign store     = push & passes(in_req_i.kind);
    assign take      = valid_q & out_ready_i;
    assign last_beat = (BEATS == 1) | beat_q;
    assign pop       = take & last_beat;

    // Next buffer contents
    always_comb
    begin
        slot0_d = slot0_q;
        slot1_d = slot1_q;
        count_d = count_q;
        case (count_q)
            2'd0:
            begin
                if (store)
                begin
                    slot0_d = new_desc;
                    count_d = 2'd1;
                end
            end
            2'd1:
            begin
                if (store && pop)
                begin
                    slot0_d = new_desc;
                end
                else if (store)
                begin
                    slot1_d = new_desc;
                    count_d = 2'd2;
                end
                else if (pop)
                begin
                    count_d = 2'd0;
                end
            end
            2'd2:
            begin
                if (pop)
                begin
                    slot0_d = slot1_q;
                    count_d = 2'd1;
                end
            end
            default:
            begin
                count_d = 2'd0;
            end
        endcase
    end

    // Beat position within the descriptor
    always_comb
    begin
        beat_d = beat_q;
        if (take)
        begin
            beat_d = last_beat ? 1'b0 : 1'b1;
        end
    end

    assign sel_beat = beat_d ? {{HALF_W{1'b0}}, slot0_d[DESC_W-1:HALF_W]} : slot0_d;

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            slot0_q <= RST_DESC;
            slot1_q <= RST_DESC;
            count_q <= 2'd0;
        end
        else
        begin
            slot0_q <= slot0_d;
            slot1_q <= slot1_d;
            count_q <= count_d;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            beat_q <= 1'b0;
        end
        else
        begin
            beat_q <= beat_d;
        end
    end

    // Registered stream outputs
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ready_q <= 1'b0;
            valid_q <= 1'b0;
            data_q  <= '0;
            last_q  <= 1'b0;
        end
        else
        begin
            ready_q <= (count_d != 2'd2);
            valid_q <= (count_d != 2'd0);
            data_q  <= sel_beat[OUT_W-1:0];
            last_q  <= (BEATS == 1) | beat_d;
        end
    end

    // Discarded request indication
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            drop_q <= 1'b0;
        end
        else
        begin
            drop_q <= push & ~store;
        end
    end

    assign in_ready_o  = ready_q;
    assign out_valid_o = valid_q;
    assign out_data_o  = data_q;
    assign out_last_o  = last_q;
    assign drop_o      = drop_q;

endmodule : completer_request_descriptor

`default_nettype wire

/* dv/completer_request_descriptor_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module completer_request_descriptor_asserts
    import completer_request_descriptor_pkg::*;
#(
    parameter int STREAM_W = 128
)
(
    input wire logic         clk_i,
    input wire logic         rst_i,
    input wire logic         in_valid_i,
    input wire req_info_t    in_req_i,
    input wire logic         in_ready_o,
    input wire logic         out_valid_o,
    input wire logic [127:0] out_data_o,
    input wire logic         out_last_o,
    input wire logic         out_ready_i,
    input wire logic         drop_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [3:0] ty;
    logic       take;
    assign ty = out_data_o[78:75];
    assign take = in_valid_i && in_ready_o;
    sequence s_take_cfg;
        take && (in_req_i.kind inside {[REQ_CFG0_RD:REQ_CFG1_WR]});
    endsequence
    sequence s_take_empty;
        take && !out_valid_o && !(in_req_i.kind inside {[REQ_LOCK_RD:REQ_CFG1_WR]});
    endsequence
    a_take_answer: assert property (s_take_empty |=> out_valid_o && out_last_o)
        else $error("no descriptor after take");
    a_type_copy: assert property (s_take_empty |=> ty == $past(in_req_i.kind))
        else $error("request type not copied");
    a_class_copy: assert property (s_take_empty |=>
        out_data_o[125:121] == $past({in_req_i.ro, in_req_i.ns, in_req_i.tc}))
        else $error("class or attributes not copied");
    a_bar_even: assert property (s_take_empty ##0 (in_req_i.bar_is_64 && !in_req_i.rom_hit
        && in_req_i.kind < REQ_MSG) |=> !out_data_o[112]) else $error("odd bar for pair");
    a_cfg_drop: assert property (s_take_cfg |=> drop_o)
        else $error("config request not dropped");
    a_no_cfg_type: assert property (out_valid_o |-> !(ty inside {[4'h8:4'hB], 4'hF}))
        else $error("forbidden type on stream");
    a_ido_kinds: assert property (out_valid_o && out_data_o[126] |-> !(ty inside {4'h2, 4'h3}))
        else $error("ordering flag on io request");
    a_bar_range: assert property (out_valid_o && ty < 4'h8 |-> out_data_o[114:112] != 3'h7)
        else $error("bar number out of range");
    a_msg_no_aper: assert property (out_valid_o && ty >= 4'hC |-> out_data_o[120:115] == 6'h0)
        else $error("aperture on message");
    a_stall_hold: assert property (out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o))
        else $error("beat changed under stall");
endmodule : completer_request_descriptor_asserts
bind completer_request_descriptor completer_request_descriptor_asserts #(.STREAM_W(STREAM_W))
    u_asserts (.clk_i(clk_i), .rst_i(rst_i), .in_valid_i(in_valid_i), .in_req_i(in_req_i),
    .in_ready_o(in_ready_o), .out_valid_o(out_valid_o), .out_data_o(out_data_o),
    .out_last_o(out_last_o), .out_ready_i(out_ready_i), .drop_o(drop_o));
`default_nettype wire

/* dv/client_sink.sv */
`timescale 1ns/10ps
`default_nettype none
module client_sink
(
    input wire logic         clk_i,
    input wire logic         rst_i,
    input wire logic         valid_i,
    input wire logic [127:0] data_i,
    input wire logic         stall_i,
    output logic             ready_o
);
    logic [127:0] got[$];
    always @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            ready_o <= 1'b0;
        else
        begin
            // Keeps every accepted beat for the testbench checks
            if (valid_i && ready_o)
                got.push_back(data_i);
            ready_o <= #1 !stall_i;
        end
    end
endmodule : client_sink
`default_nettype wire

/* dv/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
    import completer_request_descriptor_pkg::*;
    typedef struct packed {req_kind_t k; msg_kind_t m; logic b64, rom, vf; logic [2:0] rt;} row_t;
    logic         clk_i, rst_i, in_valid_i, in_ready_o, out_valid_o, out_last_o;
    logic         out_ready_i, drop_o, stall;
    logic [127:0] out_data_o;
    req_info_t    in_req_i, base, r;
    int           num_errors, n_tests, drops;
    row_t rows[13] = '{'{REQ_MEM_RD, MSG_GENERAL, 1, 0, 0, 0}, '{REQ_MEM_WR, MSG_GENERAL, 0, 1, 0, 0},
        '{REQ_IO_RD, MSG_GENERAL, 0, 0, 1, 0}, '{REQ_IO_WR, MSG_GENERAL, 0, 0, 0, 0},
        '{REQ_FADD, MSG_GENERAL, 1, 0, 0, 0}, '{REQ_SWAP, MSG_GENERAL, 0, 0, 0, 0},
        '{REQ_CAS, MSG_GENERAL, 0, 0, 1, 0}, '{REQ_MSG, MSG_LTR, 0, 0, 0, 4},
        '{REQ_MSG, MSG_OBFF, 0, 0, 0, 3}, '{REQ_MSG, MSG_GENERAL, 0, 0, 0, 1},
        '{REQ_MSG_VDM, MSG_GENERAL, 0, 0, 0, 2}, '{REQ_MSG_VDM, MSG_GENERAL, 0, 0, 0, 0},
        '{REQ_MSG_ATS, MSG_GENERAL, 0, 0, 0, 2}};

    completer_request_descriptor #(.STREAM_W(128), .LEGACY_DEV(1'b0)) u_completer_request_descriptor (
        .clk_i(clk_i), .rst_i(rst_i), .in_valid_i(in_valid_i), .in_req_i(in_req_i),
        .in_ready_o(in_ready_o), .out_valid_o(out_valid_o), .out_data_o(out_data_o),
        .out_last_o(out_last_o), .out_ready_i(out_ready_i), .drop_o(drop_o));
    client_sink u_client_sink (.clk_i(clk_i), .rst_i(rst_i), .valid_i(out_valid_o),
        .data_i(out_data_o), .stall_i(stall), .ready_o(out_ready_i));

    function automatic logic [127:0] exp_desc(input req_info_t q);
        logic [127:0] d;
        logic         io;
        d = '0;
        io = q.kind inside {REQ_IO_RD, REQ_IO_WR};
        d[78:64] = {q.kind, q.dw_cnt};
        d[103:80] = {q.tag, q.req_id};
        d[126:121] = {q.ido && !io, q.ro, q.ns, q.tc};
        if (q.kind < REQ_MSG)
        begin
            d[63:2] = q.addr;
            d[1:0] = io ? 2'h0 : q.at;
            d[111:104] = q.tgt_func;
            d[114:112] = q.rom_hit ? BAR_ROM_ID : {q.bar_num[2:1], q.bar_num[0] & !q.bar_is_64};
            d[120:115] = q.is_vf ? q.vf_aper : q.bar_aper;
        end
        else
        begin
            d[114:104] = {q.msg_route, q.msg_code};
            if (q.kind == REQ_MSG_ATS)
                d[63:0] = {q.hdr_dw3, q.hdr_dw2};
            else if (q.kind == REQ_MSG_VDM)
                d[63:0] = {q.hdr_dw3, 16'h0, q.msg_route == ROUTE_BY_ID ? q.dest_id : 16'h0};
            else if (q.msg_kind == MSG_LTR)
                d[31:0] = {q.ltr_nosnoop, q.ltr_snoop};
            else if (q.msg_kind == MSG_OBFF)
                d[35:32] = q.obff;
        end
        return d;
    endfunction : exp_desc

    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic send(input req_info_t q);
        in_req_i = q;
        in_valid_i = 1'b1;
        @(negedge clk_i);
        while (in_ready_o !== 1'b1)
            @(negedge clk_i);
        @(posedge clk_i);
        #1;
    endtask : send

    task automatic idle(input int n);
        in_valid_i = 1'b0;
        repeat (n) @(posedge clk_i);
        #1;
    endtask : idle

    task automatic close_out;
        $display("tests %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : close_out

    initial
    begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    initial
    begin
        #20000;
        num_errors++;
        close_out();
    end

    always @(posedge clk_i)
        if (drop_o === 1'b1)
            drops++;

    initial
    begin
        base = '{kind: REQ_MEM_RD, msg_kind: MSG_GENERAL, addr: 62'h1234_5678_9ABC_DEF, at: 2'h2,
            dw_cnt: 11'h1A5, req_id: 16'hBEEF, tag: 8'h5A, tgt_func: 8'h41, bar_num: 3'h3,
            bar_aper: 6'h0C, vf_aper: 6'h15, tc: 3'h5, ns: 1'b1, ro: 1'b1, ido: 1'b1, msg_code: 8'h7E,
            ltr_snoop: 16'h1111, ltr_nosnoop: 16'h2222, obff: 4'hF, dest_id: 16'h3344,
            hdr_dw2: 32'hA5A5_0001, hdr_dw3: 32'h5A5A_0002, default: '0};
        {rst_i, in_valid_i, stall, num_errors, n_tests, drops} = {3'b100, 96'h0};
        in_req_i = base;
        repeat (10) @(posedge clk_i);
        #1;
        check({in_ready_o, out_valid_o, out_last_o, drop_o}, 4'h0);
        check(out_data_o, '0);
        $display("reset done");
        rst_i = 1'b0;
        foreach (rows[i])
        begin
            r = base;
            {r.kind, r.msg_kind, r.bar_is_64, r.rom_hit, r.is_vf, r.msg_route} = rows[i];
            send(r);
            idle(3);
            check(u_client_sink.got.size(), 1);
            check(u_client_sink.got.pop_front(), exp_desc(r));
            $display("row %0d done", i);
        end
        for (int k = 7; k < 12; k++)
        begin
            r = base;
            r.kind = req_kind_t'(k);
            send(r);
            idle(3);
        end
        check(drops, 5);
        check(u_client_sink.got.size(), 0);
        $display("refused kinds done");
        stall = 1'b1;
        for (int j = 0; j < 2; j++)
        begin
            r.kind = REQ_MEM_WR;
            r.tag = 8'(j);
            send(r);
        end
        idle(4);
        check(in_ready_o, 0);
        stall = 1'b0;
        r.tag = 8'h2;
        send(r);
        idle(6);
        check(u_client_sink.got.size(), 3);
        for (int j = 0; j < 3; j++)
            check(u_client_sink.got[j][103:96], j);
        $display("stall and order done");
        stall = 1'b1;
        send(r);
        idle(1);
        rst_i = 1'b1;
        #1;
        check({in_ready_o, out_valid_o, out_last_o, drop_o}, 4'h0);
        check(out_data_o, '0);
        @(posedge clk_i);
        #1;
        rst_i = 1'b0;
        stall = 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
        check({in_ready_o, out_valid_o, out_last_o}, 3'b101);
        check(u_client_sink.got.size(), 3);
        $display("mid-run reset done");
        close_out();
    end
endmodule : tb
`default_nettype wire
